// ==== hdl/output_busy_pin.sv ====
// The strobed register port and the register addresses were left to the implementer.
`include "busy_pin_map.svh"
module output_busy_pin #(
  parameter int unsigned CLK_HZ = `CLK_HZ
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Unit status
  input wire logic busy_i,
  input wire logic xon_xoff_en_i,
  // Pin
  output logic pin_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] tmo;
    logic [7:0] left;
    logic [7:0] unit_sec;
    logic [31:0] presc;
    logic [7:0] rdata;
    logic pin;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  busy_pin_pkg::unit_t unit;
  logic active;
  logic sec_tick;
  logic unit_tick;

  // ----------------------------------------
  // Timeout unit and enables
  // ----------------------------------------

  // Unit decode; hundreds wins if both bits set
  always_comb begin
    if (s_r.cfg[`CFG_HUND_BIT]) begin
      unit = busy_pin_pkg::UNIT_HUND;
    end else if (s_r.cfg[`CFG_MIN_BIT]) begin
      unit = busy_pin_pkg::UNIT_MIN;
    end else begin
      unit = busy_pin_pkg::UNIT_SEC;
    end
  end

  // Timeout counts only in output mode while running
  assign active = s_r.cfg[`CFG_FUNC_BIT] && s_r.cfg[`CFG_RUN_BIT];
  assign sec_tick = active && (s_r.presc == CLK_HZ - 1);
  assign unit_tick = sec_tick && (s_r.unit_sec == 8'h00);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic lvl;
    lvl = 1'b0;
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    // Prescaler to one-second enable
    if (!active) begin
      s_nxt.presc = 32'h0000_0000;
    end else if (sec_tick) begin
      s_nxt.presc = 32'h0000_0000;
    end else begin
      s_nxt.presc = s_r.presc + 32'h0000_0001;
    end
    // Seconds within one timeout unit
    if (sec_tick) begin
      if (s_r.unit_sec == 8'h00) begin
        case (unit)
          busy_pin_pkg::UNIT_MIN: s_nxt.unit_sec = 8'(`SEC_PER_MIN - 1);
          busy_pin_pkg::UNIT_HUND: s_nxt.unit_sec = 8'(`SEC_PER_HUND - 1);
          default: s_nxt.unit_sec = 8'h00;
        endcase
      end else begin
        s_nxt.unit_sec = s_r.unit_sec - 8'h01;
      end
    end
    // Remaining units; expiry turns output off and halts
    if (unit_tick && s_r.left != 8'h00) begin
      s_nxt.left = s_r.left - 8'h01;
      if (s_r.left == 8'h01) begin
        s_nxt.cfg[`CFG_DONE_BIT] = 1'b1;
        s_nxt.cfg[`CFG_RUN_BIT] = 1'b0;
        s_nxt.cfg[`CFG_ON_BIT] = 1'b0;
      end
    end
    // Register writes
    if (wr_i) begin
      case (addr_i)
        `PIN_CFG_OFS: begin
          // Busy mode refused while XON/XOFF on
          s_nxt.cfg[7:1] = wdata_i[7:1];
          if (xon_xoff_en_i) begin
            s_nxt.cfg[`CFG_FUNC_BIT] = 1'b1;
          end
          if (wdata_i[`CFG_RUN_BIT] && !s_r.cfg[`CFG_RUN_BIT]) begin
            s_nxt.left = s_r.tmo;
            // First unit runs its full length, not a single second
            if (wdata_i[`CFG_HUND_BIT]) begin
              s_nxt.unit_sec = 8'(`SEC_PER_HUND - 1);
            end else if (wdata_i[`CFG_MIN_BIT]) begin
              s_nxt.unit_sec = 8'(`SEC_PER_MIN - 1);
            end else begin
              s_nxt.unit_sec = 8'h00;
            end
            s_nxt.presc = 32'h0000_0000;
            s_nxt.cfg[`CFG_DONE_BIT] = 1'b0;
          end
        end
        `PIN_TMO_OFS: begin
          if (wdata_i >= `TMO_MIN) begin
            s_nxt.tmo = wdata_i;
          end
        end
        default: begin
        end
      endcase
    end
    // XON/XOFF turned on forces output mode
    if (xon_xoff_en_i) begin
      s_nxt.cfg[`CFG_FUNC_BIT] = 1'b1;
    end
    // Register reads
    if (rd_i) begin
      case (addr_i)
        `PIN_CFG_OFS: s_nxt.rdata = s_r.cfg;
        `PIN_TMO_OFS: s_nxt.rdata = s_r.tmo;
        `PIN_CTL_OFS: s_nxt.rdata = s_r.left;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // Pin level: logical state, then polarity
    if (s_r.cfg[`CFG_FUNC_BIT]) begin
      lvl = s_r.cfg[`CFG_ON_BIT];
    end else begin
      lvl = busy_i && !xon_xoff_en_i;
    end
    s_nxt.pin = s_r.cfg[`CFG_POL_BIT] ? lvl : !lvl;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.cfg <= `CFG_RESET;
      s_r.tmo <= `TMO_DEFAULT;
      s_r.pin <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign pin_o = s_r.pin;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_pin_polarity: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_r.cfg[`CFG_FUNC_BIT] |=> pin_o == ($past(s_r.cfg[`CFG_POL_BIT]) ~^ $past(s_r.cfg[`CFG_ON_BIT])))
    else $error("pin level wrong in output mode");
  chk_busy_blocked: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    xon_xoff_en_i |=> s_r.cfg[`CFG_FUNC_BIT])
    else $error("busy mode kept with xon/xoff");
  chk_busy_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!s_r.cfg[`CFG_FUNC_BIT] && !xon_xoff_en_i) |=> pin_o == ($past(busy_i) ~^ $past(s_r.cfg[6])))
    else $error("busy level wrong");
  chk_tmo_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_r.tmo >= `TMO_MIN) else $error("timeout value out of range");
  chk_tmo_ignore: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `PIN_TMO_OFS && wdata_i == 8'h00) |=> $stable(s_r.tmo))
    else $error("zero timeout accepted");
  chk_expire_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (unit_tick && s_r.left == 8'h01 && !wr_i) |=> s_r.cfg[`CFG_DONE_BIT] && !s_r.cfg[3])
    else $error("expiry not flagged");
  chk_halt_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!s_r.cfg[`CFG_FUNC_BIT] || !s_r.cfg[`CFG_RUN_BIT]) |=> s_r.presc == 32'h0000_0000)
    else $error("timeout counts while halted");
  chk_min_unit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (unit_tick && unit == busy_pin_pkg::UNIT_MIN) |=> s_r.unit_sec == 8'(`SEC_PER_MIN - 1))
    else $error("minute unit wrong");
  chk_hund_unit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (unit_tick && unit == busy_pin_pkg::UNIT_HUND) |=> s_r.unit_sec == 8'(`SEC_PER_HUND - 1))
    else $error("hundreds unit wrong");
  chk_sec_unit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (sec_tick && unit == busy_pin_pkg::UNIT_SEC) |-> unit_tick)
    else $error("seconds unit wrong");
  chk_read_cfg: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `PIN_CFG_OFS) |=> rdata_o == $past(s_r.cfg))
    else $error("config readback wrong");

  // Steps of a timeout start
  sequence start_req_s;
    wr_i && addr_i == `PIN_CFG_OFS && wdata_i[`CFG_RUN_BIT] && !s_r.cfg[`CFG_RUN_BIT];
  endsequence
  sequence loaded_s;
    s_r.left == $past(s_r.tmo) && !s_r.cfg[`CFG_DONE_BIT];
  endsequence

  // Start loads the remaining count and clears the flag
  chk_start_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    start_req_s |=> loaded_s)
    else $error("timeout start not loaded");

  // First hundreds unit lasts a full unit
  chk_hund_first: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    start_req_s ##0 wdata_i[`CFG_HUND_BIT] |=> s_r.unit_sec == 8'(`SEC_PER_HUND - 1))
    else $error("first hundreds unit short");

  // First minute unit lasts a full minute
  chk_min_first: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    start_req_s ##0 (!wdata_i[`CFG_HUND_BIT] && wdata_i[`CFG_MIN_BIT])
      |=> s_r.unit_sec == 8'(`SEC_PER_MIN - 1))
    else $error("first minute unit short");

  // Expired flag holds until the next start
  chk_done_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_r.cfg[`CFG_DONE_BIT] && !(wr_i && addr_i == `PIN_CFG_OFS && wdata_i[`CFG_RUN_BIT]
      && !s_r.cfg[`CFG_RUN_BIT])) |=> s_r.cfg[`CFG_DONE_BIT])
    else $error("expired flag lost");

  // Expired flag is set only by expiry
  chk_done_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!s_r.cfg[`CFG_DONE_BIT] && !(unit_tick && s_r.left == 8'h01)) |=> !s_r.cfg[`CFG_DONE_BIT])
    else $error("expired flag set early");

  // Configuration and value reset
  chk_reset_cfg: assert property (@(posedge ref_clk_i)
    !rst_n_i |=> s_r.cfg == `CFG_RESET && s_r.tmo == `TMO_DEFAULT)
    else $error("reset values wrong");

  // Outputs after reset
  chk_reset_pin: assert property (@(posedge ref_clk_i)
    !rst_n_i |=> pin_o && rdata_o == 8'h00)
    else $error("outputs wrong after reset");

  // Read data stands only after a read
  chk_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data without read");

  // Timeout value readback
  chk_read_tmo: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `PIN_TMO_OFS) |=> rdata_o == $past(s_r.tmo))
    else $error("timeout readback wrong");

  // Remaining count readback
  chk_read_left: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `PIN_CTL_OFS) |=> rdata_o == $past(s_r.left))
    else $error("remaining readback wrong");

  // Legal timeout value is taken
  chk_tmo_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `PIN_TMO_OFS && wdata_i >= `TMO_MIN) |=> s_r.tmo == $past(wdata_i))
    else $error("timeout value not taken");

  // Lock bit is stored as written
  chk_lock_store: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `PIN_CFG_OFS) |=> s_r.cfg[`CFG_LOCK_BIT] == $past(wdata_i[`CFG_LOCK_BIT]))
    else $error("lock bit not stored");

  // Polarity bit is stored as written
  chk_pol_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `PIN_CFG_OFS) |=> s_r.cfg[`CFG_POL_BIT] == $past(wdata_i[`CFG_POL_BIT]))
    else $error("polarity bit not stored");

  // Function bit is stored while flow control is off
  chk_func_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `PIN_CFG_OFS && !xon_xoff_en_i)
      |=> s_r.cfg[`CFG_FUNC_BIT] == $past(wdata_i[`CFG_FUNC_BIT]))
    else $error("function bit not stored");

  // Busy level suppressed while flow control is on
  chk_busy_xon_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!s_r.cfg[`CFG_FUNC_BIT] && xon_xoff_en_i) |=> pin_o == !$past(s_r.cfg[`CFG_POL_BIT]))
    else $error("busy shown with xon/xoff");

  // Each unit tick takes one from a nonzero count
  chk_left_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (unit_tick && s_r.left != 8'h00 && !wr_i) |=> s_r.left == $past(s_r.left) - 8'h01)
    else $error("remaining count step wrong");

  // Prescaler advances while running
  chk_presc_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (active && !sec_tick && !wr_i) |=> s_r.presc == $past(s_r.presc) + 32'h0000_0001)
    else $error("prescaler stalled");

endmodule // output_busy_pin

// ==== hdl/busy_pin_map.svh ====
`ifndef BUSY_PIN_MAP_SVH
`define BUSY_PIN_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PIN_CFG_OFS 4'h0
`define PIN_TMO_OFS 4'h1
`define PIN_CTL_OFS 4'h2
// ----------------------------------------
// Field positions of the configuration byte
// ----------------------------------------
`define CFG_FUNC_BIT 7
`define CFG_POL_BIT 6
`define CFG_ON_BIT 5
`define CFG_LOCK_BIT 4
`define CFG_RUN_BIT 3
`define CFG_HUND_BIT 2
`define CFG_MIN_BIT 1
`define CFG_DONE_BIT 0
// ----------------------------------------
// Reset values and ranges
// ----------------------------------------
`define CFG_RESET 8'h00
`define TMO_DEFAULT 8'h0A
`define TMO_MIN 8'h01
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 40000000
`define SEC_PER_MIN 60
`define SEC_PER_HUND 100
`endif

// ==== hdl/busy_pin_pkg.sv ====
package busy_pin_pkg;
  // Timeout unit as picked by the two select bits
  typedef enum logic [1:0] {
    UNIT_SEC,
    UNIT_MIN,
    UNIT_HUND
  } unit_t;
endpackage

// ==== verification/pin_watcher.sv ====
// ----------------------------------------
// Far-side equipment watching the pin
// ----------------------------------------
module pin_watcher (
  // Clock and pin
  input wire logic ref_clk_i,
  input wire logic pin_i,
  // Count of level changes seen
  output int unsigned n_edges_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r = 1'b1;
  initial n_edges_o = 0;
  // Counts every change of level, sampled like a slow input
  always @(posedge ref_clk_i) begin
    if (pin_i !== last_r) n_edges_o <= n_edges_o + 1;
    last_r <= pin_i;
  end
endmodule // pin_watcher

// ==== verification/output_busy_pin_bench.sv ====
module output_busy_pin_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int unsigned HZ = 4; // Short second keeps the run brief
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic busy_i = 1'b0, xon_xoff_en_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  wire logic [7:0] rdata_o;
  wire logic pin_o;
  int unsigned n_edges, e0, n;
  int n_errors = 0, cmp_count = 0;
  logic [7:0] cfg_tab [4] = '{8'hE0, 8'hC0, 8'hA0, 8'h90};
  logic pin_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] unit_tab [3] = '{8'h00, 8'h02, 8'h04};
  int unsigned mult_tab [3] = '{1, 60, 100};
  always #12.5 ref_clk_i = ~ref_clk_i;
  output_busy_pin #(.CLK_HZ(HZ)) output_busy_pin_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .busy_i(busy_i), .xon_xoff_en_i(xon_xoff_en_i), .pin_o(pin_o));
  pin_watcher pin_watcher_i (.ref_clk_i(ref_clk_i), .pin_i(pin_o), .n_edges_o(n_edges));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 check("read data", rdata_o, exp);
  endtask
  task automatic pin_is(input logic exp);
    repeat (2) @(posedge ref_clk_i);
    #1 check("pin level", {7'h00, pin_o}, {7'h00, exp});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h0A);
    pin_is(1'b1);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h0A);
    rd(4'hF, 8'h00);
    @(posedge ref_clk_i) busy_i <= 1'b1;
    pin_is(1'b0);
    wr(4'h0, 8'h40);
    pin_is(1'b1);
    @(posedge ref_clk_i) xon_xoff_en_i <= 1'b1;
    rd(4'h0, 8'hC0);
    pin_is(1'b0);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h80);
    @(posedge ref_clk_i) xon_xoff_en_i <= 1'b0;
    // Output mode: polarity, on/off and lock
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, cfg_tab[i]);
      pin_is(pin_tab[i]);
      rd(4'h0, cfg_tab[i]);
    end
    // Timeout of two units in each unit, measured at the pin
    wr(4'h1, 8'h02);
    for (int u = 0; u < 3; u++) begin
      wr(4'h0, 8'hC0);
      wr(4'h0, 8'hE8 | unit_tab[u]);
      #1 e0 = n_edges;
      n = 0;
      while (n_edges < e0 + 2) begin
        @(posedge ref_clk_i);
        #1 n++;
        if (n > 1000) begin
          n_errors++;
          final_report();
        end
      end
      check("timeout length", {7'h00, n + 2 >= 2 * mult_tab[u] * HZ}, 8'h01);
      check("timeout bound", {7'h00, n <= 2 * mult_tab[u] * HZ + 5}, 8'h01);
      rd(4'h0, 8'hC1 | unit_tab[u]);
      rd(4'h2, 8'h00);
      check("pin after timeout", {7'h00, pin_o}, 8'h00);
    end
    final_report();
  end
endmodule // output_busy_pin_bench
